// ===== mdio_station.sv
/*
 * Station management master model: clocks whole frames onto the pins and
 * reads back what the device drives.
 * Assumes clk runs; the data wire has a pull-up; mdc stands low between frames.
 */
`timescale 1ns/10ps
`default_nettype none
module mdio_station (
    input  wire logic clk,
    output logic      mdc,
    output logic      mdio_in,
    input  wire logic mdio_out,
    input  wire logic mdio_oe
);
    logic drv;
    logic bit_q;

    // Wire level: device, else station, else the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (drv ? bit_q : 1'b1);

    initial begin
        mdc   = 1'b0;
        drv   = 1'b0;
        bit_q = 1'b1;
    end

    // One bit: data changes while mdc is low, wire read just before the rise
    task automatic cyc(input logic b, input logic d, output logic s);
        @(posedge clk);
        mdc   <= 1'b0;
        drv   <= d;
        bit_q <= b;
        repeat (7) @(posedge clk);
        s = mdio_in;
        mdc <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] hdr;
        logic        wr;
        logic        s;
        hdr = {2'h1, op, pa, ra};
        wr  = (op == 2'h1);
        for (int i = 0; i < pre; i++) begin
            cyc(1'b1, 1'b1, s);
        end
        for (int i = 13; i >= 0; i--) begin
            cyc(hdr[i], 1'b1, s);
        end
        cyc(1'b1, wr, s);
        cyc(1'b0, wr, s);
        for (int i = 15; i >= 0; i--) begin
            cyc(wd[i], wr, s);
            rd[i] = s;
        end
        @(posedge clk);
        mdc <= 1'b0;
        drv <= 1'b0;
        repeat (16) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== phy_basic_consts.svh
/*
 * Named constants of the basic control and status registers and of the
 * serial management frame.
 * Assumes inclusion by bare name from the design module.
 */
// How it works
// - Duplex bit forces duplex unless negotiating
// - Collision test echoes transmit enable on collision
// - Reserved bits read zero, master writes zero
// - 100BASE-T4 capability bit fixed zero
// - 100BASE-TX full and half capability fixed one
// - 10BASE-T full and half capability fixed one
// - Preamble suppression reads zero; short preambles rejected
// - Negotiation complete bit follows negotiation state
// - Remote fault latches high, clears on read
// - Negotiation ability bit fixed one
// - Link bit latches low until status read
// - Jabber latches high in 10 Mbps only
// - Extended capability bit fixed one
// - Negotiation enable selects resolved speed and duplex
`ifndef PHY_BASIC_CONSTS_SVH
`define PHY_BASIC_CONSTS_SVH

`define REG_CONTROL        5'h00
`define REG_STATUS         5'h01

`define CTL_RESET_BIT      15
`define CTL_SPEED_BIT      13
`define CTL_ANEG_BIT       12
`define CTL_DUPLEX_BIT     8
`define CTL_COLTEST_BIT    7

`define CTL_SPEED_RST      1'h1
`define CTL_ANEG_RST       1'h1
`define CTL_DUPLEX_RST     1'h1
`define CTL_COLTEST_RST    1'h0

`define STS_T4_BIT         15
`define STS_TX_FD_BIT      14
`define STS_TX_HD_BIT      13
`define STS_10_FD_BIT      12
`define STS_10_HD_BIT      11
`define STS_PRESUP_BIT     6
`define STS_ANDONE_BIT     5
`define STS_RFAULT_BIT     4
`define STS_ANABLE_BIT     3
`define STS_LINK_BIT       2
`define STS_JABBER_BIT     1
`define STS_EXTCAP_BIT     0

`define MF_PREAMBLE_LEN    6'h20
`define MF_OP_LEN          6'h02
`define MF_ADDR_LEN        6'h0A
`define MF_DATA_LEN        6'h10
`define MF_OP_READ         2'h2
`define MF_OP_WRITE        2'h1

`endif

// ===== phy_basic_mode_ctrl_status.sv
/*
 * Basic control and status registers of a 10/100 PHY reached over the
 * serial management pins, with the collision test path.
 * Assumes mdc, mdio and tx_en come from outside this clock domain; the
 * negotiation, link and jabber inputs come from PHY logic on clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "phy_basic_consts.svh"

module phy_basic_mode_ctrl_status (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [4:0] phy_addr,
    input  wire logic       mdc,
    input  wire logic       mdio_in,
    output logic            mdio_out,
    output logic            mdio_oe,
    input  wire logic       tx_en,
    input  wire logic       col_in,
    output logic            col,
    input  wire logic       an_complete,
    input  wire logic       an_full_duplex,
    input  wire logic       an_speed_100,
    input  wire logic       partner_remote_fault,
    input  wire logic       link_ok,
    input  wire logic       jabber_detect,
    output logic            full_duplex,
    output logic            speed_100
);

    logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2, tx_en_s1, tx_en_s2;

    always_ff @(posedge clk) begin
        mdc_s1   <= mdc;
        mdc_s2   <= mdc_s1;
        mdc_s3   <= mdc_s2;
        mdio_s1  <= mdio_in;
        mdio_s2  <= mdio_s1;
        tx_en_s1 <= tx_en;
        tx_en_s2 <= tx_en_s1;
    end

    logic mdc_rise;
    assign mdc_rise = mdc_s2 & ~mdc_s3;

    // Frame machine state
    phy_basic_pkg::mf_state_t state, next_state;
    logic [5:0]  cnt, next_cnt;
    logic [1:0]  op, next_op;
    logic [9:0]  addr, next_addr;
    logic [15:0] shift, next_shift;
    logic        is_read, next_is_read;
    logic        next_mdio_out, next_mdio_oe;
    logic        wr_stb, next_wr_stb;
    logic        sts_read;
    logic [15:0] rdata;

    // Register state
    phy_basic_pkg::ctrl_t  ctrl, next_ctrl;
    phy_basic_pkg::flags_t flags, next_flags;
    logic next_col, next_full_duplex, next_speed_100;
    logic soft_reset;

    logic [4:0] reg_sel;
    logic       addr_hit;
    assign reg_sel  = next_addr[4:0];
    assign addr_hit = (next_addr[9:5] == phy_addr);

    // Read word, live flags shown before the read clears them
    always_comb begin
        rdata = 16'h0000;
        if (reg_sel == `REG_CONTROL) begin
            rdata[`CTL_SPEED_BIT]   = speed_100;
            rdata[`CTL_ANEG_BIT]    = ctrl.aneg;
            rdata[`CTL_DUPLEX_BIT]  = full_duplex;
            rdata[`CTL_COLTEST_BIT] = ctrl.coltest;
        end else if (reg_sel == `REG_STATUS) begin
            rdata[`STS_T4_BIT]     = 1'b0;
            rdata[`STS_TX_FD_BIT]  = 1'b1;
            rdata[`STS_TX_HD_BIT]  = 1'b1;
            rdata[`STS_10_FD_BIT]  = 1'b1;
            rdata[`STS_10_HD_BIT]  = 1'b1;
            rdata[`STS_PRESUP_BIT] = 1'b0;
            rdata[`STS_ANDONE_BIT] = an_complete;
            rdata[`STS_RFAULT_BIT] = flags.rfault;
            rdata[`STS_ANABLE_BIT] = 1'b1;
            rdata[`STS_LINK_BIT]   = link_ok & ~flags.link_fail;
            rdata[`STS_JABBER_BIT] = flags.jabber;
            rdata[`STS_EXTCAP_BIT] = 1'b1;
        end
    end

    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_op       = op;
        next_addr     = addr;
        next_shift    = shift;
        next_is_read  = is_read;
        next_mdio_out = mdio_out;
        next_mdio_oe  = mdio_oe;
        next_wr_stb   = 1'b0;
        sts_read      = 1'b0;
        if (mdc_rise) begin
            unique case (state)
                phy_basic_pkg::MF_PRE: begin
                    if (mdio_s2) begin
                        if (cnt != `MF_PREAMBLE_LEN)
                            next_cnt = cnt + 6'h01;
                    end else if (cnt == `MF_PREAMBLE_LEN) begin
                        next_state = phy_basic_pkg::MF_ST;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
                phy_basic_pkg::MF_ST: begin
                    next_cnt   = 6'h00;
                    next_state = mdio_s2 ? phy_basic_pkg::MF_OP : phy_basic_pkg::MF_PRE;
                end
                phy_basic_pkg::MF_OP: begin
                    next_op  = {op[0], mdio_s2};
                    next_cnt = cnt + 6'h01;
                    if (next_cnt == `MF_OP_LEN) begin
                        next_cnt   = 6'h00;
                        next_state = phy_basic_pkg::MF_ADDR;
                        if (next_op != `MF_OP_READ && next_op != `MF_OP_WRITE)
                            next_state = phy_basic_pkg::MF_PRE;
                    end
                end
                phy_basic_pkg::MF_ADDR: begin
                    next_addr = {addr[8:0], mdio_s2};
                    next_cnt  = cnt + 6'h01;
                    if (next_cnt == `MF_ADDR_LEN) begin
                        next_cnt     = 6'h00;
                        next_state   = phy_basic_pkg::MF_TA;
                        next_is_read = (op == `MF_OP_READ) && addr_hit;
                        if (next_is_read) begin
                            next_shift = rdata;
                            sts_read   = (reg_sel == `REG_STATUS);
                        end
                    end
                end
                phy_basic_pkg::MF_TA: begin
                    if (cnt == 6'h00) begin
                        next_cnt      = 6'h01;
                        next_mdio_oe  = is_read;
                        next_mdio_out = 1'b0;
                    end else begin
                        next_cnt   = 6'h00;
                        next_state = phy_basic_pkg::MF_DATA;
                        if (is_read) begin
                            next_mdio_out = shift[15];
                            next_shift    = {shift[14:0], 1'b0};
                        end
                    end
                end
                phy_basic_pkg::MF_DATA: begin
                    next_cnt = cnt + 6'h01;
                    if (is_read) begin
                        next_mdio_out = shift[15];
                        next_shift    = {shift[14:0], 1'b0};
                    end else begin
                        next_shift = {shift[14:0], mdio_s2};
                    end
                    if (next_cnt == `MF_DATA_LEN) begin
                        next_cnt      = 6'h00;
                        next_state    = phy_basic_pkg::MF_PRE;
                        next_mdio_oe  = 1'b0;
                        next_mdio_out = 1'b0;
                        next_is_read  = 1'b0;
                        next_wr_stb   = (op == `MF_OP_WRITE) && (addr[9:5] == phy_addr);
                    end
                end
                default: begin
                    next_state = phy_basic_pkg::MF_PRE;
                    next_cnt   = 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state    <= phy_basic_pkg::MF_PRE;
            cnt      <= 6'h00;
            op       <= 2'h0;
            addr     <= 10'h000;
            shift    <= 16'h0000;
            is_read  <= 1'b0;
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
            wr_stb   <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            op       <= next_op;
            addr     <= next_addr;
            shift    <= next_shift;
            is_read  <= next_is_read;
            mdio_out <= next_mdio_out;
            mdio_oe  <= next_mdio_oe;
            wr_stb   <= next_wr_stb;
        end
    end

    assign soft_reset = wr_stb && (addr[4:0] == `REG_CONTROL) && shift[`CTL_RESET_BIT];

    always_comb begin
        next_ctrl  = ctrl;
        next_flags = flags;
        if (soft_reset) begin
            next_ctrl.speed   = `CTL_SPEED_RST;
            next_ctrl.aneg    = `CTL_ANEG_RST;
            next_ctrl.duplex  = `CTL_DUPLEX_RST;
            next_ctrl.coltest = `CTL_COLTEST_RST;
        end else if (wr_stb && addr[4:0] == `REG_CONTROL) begin
            next_ctrl.speed   = shift[`CTL_SPEED_BIT];
            next_ctrl.aneg    = shift[`CTL_ANEG_BIT];
            next_ctrl.duplex  = shift[`CTL_DUPLEX_BIT];
            next_ctrl.coltest = shift[`CTL_COLTEST_BIT];
        end
        // Clearing read loses to a same-cycle event
        next_flags.rfault    = (flags.rfault & ~sts_read) | partner_remote_fault;
        next_flags.link_fail = (flags.link_fail & ~sts_read) | ~link_ok;
        next_flags.jabber    = (flags.jabber & ~sts_read & ~soft_reset)
                             | (jabber_detect & ~speed_100);
        next_full_duplex = ctrl.aneg ? an_full_duplex : ctrl.duplex;
        next_speed_100   = ctrl.aneg ? an_speed_100 : ctrl.speed;
        next_col         = ctrl.coltest ? tx_en_s2 : col_in;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl.speed   <= `CTL_SPEED_RST;
            ctrl.aneg    <= `CTL_ANEG_RST;
            ctrl.duplex  <= `CTL_DUPLEX_RST;
            ctrl.coltest <= `CTL_COLTEST_RST;
            flags        <= '0;
            full_duplex  <= 1'b0;
            speed_100    <= 1'b0;
            col          <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            flags       <= next_flags;
            full_duplex <= next_full_duplex;
            speed_100   <= next_speed_100;
            col         <= next_col;
        end
    end

endmodule
`default_nettype wire

// ===== phy_basic_mode_ctrl_status_assertions.sv
/*
 * Checker of the basic control and status block at its top-level ports.
 * Assumes one clock domain and a station that reads whole frames.
 */
`timescale 1ns/10ps
`default_nettype none
module phy_basic_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic tx_en,
    input wire logic col_in,
    input wire logic col
);
    logic       mdc_q;
    logic       oe_q;
    logic       is_sts;
    logic [5:0] sh;
    logic [4:0] cnt;
    logic       rise;
    logic       rd_bit;

    assign rise   = mdc && !mdc_q;
    assign rd_bit = rise && mdio_oe;

    // Register number at turnaround, then position of each driven bit
    always_ff @(posedge clk) begin
        mdc_q  <= mdc;
        oe_q   <= mdio_oe;
        sh     <= rise ? {sh[4:0], mdio_in} : sh;
        cnt    <= (reset || !mdio_oe) ? 5'h00 : cnt + {4'h0, rise};
        is_sts <= (mdio_oe && !oe_q) ? (sh[5:1] == 5'h01) : is_sts;
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (reset);

    a_t4_zero: assert property (rd_bit && is_sts && cnt == 5'h01 |-> !mdio_out)
        else $error("status bit 15 read as one");
    a_tx_caps: assert property (rd_bit && is_sts && cnt inside {5'h02, 5'h03} |-> mdio_out)
        else $error("fast capability bit read as zero");
    a_ten_caps: assert property (rd_bit && is_sts && cnt inside {5'h04, 5'h05} |-> mdio_out)
        else $error("slow capability bit read as zero");
    a_rsvd_zero: assert property (rd_bit && ((is_sts && cnt inside {[5'h06:5'h09]}) ||
        (!is_sts && cnt >= 5'h0A)) |-> !mdio_out)
        else $error("reserved bit read as one");
    a_presup_zero: assert property (rd_bit && is_sts && cnt == 5'h0A |-> !mdio_out)
        else $error("preamble suppression bit read as one");
    a_aneg_able: assert property (rd_bit && is_sts && cnt == 5'h0D |-> mdio_out)
        else $error("negotiation ability bit read as zero");
    a_ext_cap: assert property (rd_bit && is_sts && cnt == 5'h10 |-> mdio_out)
        else $error("extended capability bit read as zero");
    a_col_cause: assert property (col |-> $past(col_in) || $past(tx_en, 3))
        else $error("collision without a cause");

    c_status_read: cover property (rd_bit && is_sts && cnt == 5'h10);
    c_control_read: cover property (rd_bit && !is_sts && cnt == 5'h10);
    c_col_test: cover property (col && !$past(col_in));
endmodule

bind phy_basic_mode_ctrl_status phy_basic_checker u_chk (.clk(clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .tx_en(tx_en), .col_in(col_in), .col(col));
`default_nettype wire

// ===== phy_basic_mode_ctrl_status_tb.sv
/*
 * Testbench of the basic control and status block: status rows, latches,
 * control writes, collision test, refused frames and chip reset.
 * Assumes the station model drives the management pins.
 */
`timescale 1ns/10ps
`default_nettype none
module phy_basic_mode_ctrl_status_tb;
    typedef struct packed {
        logic [5:0]  stim;
        logic [15:0] exp;
    } row_t;
    logic        clk;
    logic        reset;
    logic [4:0]  phy_addr;
    logic        mdc;
    logic        mdio_in;
    logic        mdio_out;
    logic        mdio_oe;
    logic        tx_en;
    logic        col_in;
    logic        col;
    logic        an_complete;
    logic        an_full_duplex;
    logic        an_speed_100;
    logic        partner_remote_fault;
    logic        link_ok;
    logic        jabber_detect;
    logic        full_duplex;
    logic        speed_100;
    logic [5:0]  live;
    logic [15:0] rd;
    int          miscompares;
    int          samples_checked;
    // Live inputs {complete, remote fault, link, jabber, speed 100, full duplex}
    row_t        rows [6] = '{'{6'h03, 16'h7809}, '{6'h2A, 16'h782D}, '{6'h1B, 16'h781D},
                              '{6'h0E, 16'h780D}, '{6'h0D, 16'h780F}, '{6'h34, 16'h783B}};

    assign {an_complete, partner_remote_fault, link_ok, jabber_detect, an_speed_100, an_full_duplex} = live;

    phy_basic_mode_ctrl_status uut (.clk(clk), .reset(reset), .phy_addr(phy_addr), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe(mdio_oe), .tx_en(tx_en), .col_in(col_in), .col(col),
        .an_complete(an_complete), .an_full_duplex(an_full_duplex), .an_speed_100(an_speed_100),
        .partner_remote_fault(partner_remote_fault), .link_ok(link_ok), .jabber_detect(jabber_detect),
        .full_duplex(full_duplex), .speed_100(speed_100));
    mdio_station st (.clk(clk), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic rdr(input logic [4:0] ra);
        st.frame(32, 2'h2, phy_addr, ra, 16'h0000, rd);
    endtask

    task automatic wrr(input logic [15:0] wd);
        st.frame(32, 2'h1, phy_addr, 5'h00, wd, rd);
    endtask

    task automatic col_chk(input logic exp);
        repeat (5) @(posedge clk);
        chk({15'h0, col}, {15'h0, exp});
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        test_done();
    end

    initial begin
        reset = 1'b1;
        phy_addr = 5'h05;
        tx_en = 1'b0;
        col_in = 1'b0;
        live = 6'h00;
        miscompares = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        chk({14'h0, mdio_oe, col}, 16'h0000);
        foreach (rows[i]) begin
            live <= rows[i].stim;
            rdr(5'h01);
            rdr(5'h01);
            chk(rd, rows[i].exp);
            chk({14'h0, speed_100, full_duplex}, {14'h0, rows[i].stim[1:0]});
        end
        live <= 6'h08;
        rdr(5'h01);
        @(posedge clk);
        live <= 6'h14;
        @(posedge clk);
        live <= 6'h08;
        rdr(5'h01);
        chk(rd, 16'h781B);
        rdr(5'h01);
        chk(rd, 16'h780D);
        wrr(16'h0100);
        chk({14'h0, speed_100, full_duplex}, 16'h0001);
        rdr(5'h00);
        chk(rd, 16'h0100);
        wrr(16'h2080);
        chk({14'h0, speed_100, full_duplex}, 16'h0002);
        tx_en <= 1'b1;
        col_chk(1'b1);
        tx_en <= 1'b0;
        col_chk(1'b0);
        live <= 6'h0B;
        wrr(16'h1000);
        rdr(5'h00);
        chk(rd, 16'h3100);
        tx_en <= 1'b1;
        col_chk(1'b0);
        col_in <= 1'b1;
        col_chk(1'b1);
        tx_en <= 1'b0;
        col_in <= 1'b0;
        st.frame(31, 2'h1, phy_addr, 5'h00, 16'h0100, rd);
        rdr(5'h00);
        chk(rd, 16'h3100);
        st.frame(32, 2'h2, phy_addr + 5'h01, 5'h01, 16'h0000, rd);
        chk(rd, 16'hFFFF);
        rdr(5'h02);
        chk(rd, 16'h0000);
        // Latch jabber at 10 Mbps, then a soft reset clears it and restores control
        live <= 6'h0C;
        repeat (3) @(posedge clk);
        live <= 6'h0B;
        wrr(16'h0080);
        wrr(16'h8000);
        rdr(5'h00);
        chk(rd, 16'h3100);
        rdr(5'h01);
        chk(rd, 16'h780D);
        @(posedge clk);
        live <= 6'h18;
        @(posedge clk);
        live <= 6'h0B;
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        chk({12'h0, mdio_oe, col, speed_100, full_duplex}, 16'h0000);
        reset <= 1'b0;
        rdr(5'h01);
        chk(rd, 16'h780D);
        test_done();
    end
endmodule
`default_nettype wire

// ===== phy_basic_pkg.sv
/*
 * Types of the basic control and status block.
 * Assumes the constants header sits in the same folder.
 */
package phy_basic_pkg;

    typedef enum logic [2:0] {
        MF_PRE  = 3'h0,
        MF_ST   = 3'h1,
        MF_OP   = 3'h2,
        MF_ADDR = 3'h3,
        MF_TA   = 3'h4,
        MF_DATA = 3'h5
    } mf_state_t;

    typedef struct packed {
        logic speed;
        logic aneg;
        logic duplex;
        logic coltest;
    } ctrl_t;

    typedef struct packed {
        logic rfault;
        logic link_fail;
        logic jabber;
    } flags_t;

endpackage
